// ==== ppc_pkg.sv ====
/*
 pixel control package: register indices, config fields, blink figures, carriers.
 assumes a single pixel clock domain; host and frame buffer pins are asynchronous.
*/
package ppc_pkg;
	localparam int PPC_NPIX = 5;
	localparam logic [2:0] PPC_IDX_READ_MASK = 3'h4;
	localparam logic [2:0] PPC_IDX_BLINK_MASK = 3'h5;
	localparam logic [2:0] PPC_IDX_CONFIG = 3'h6;
	localparam logic [2:0] PPC_IDX_TEST = 3'h7;
	localparam int PPC_CFG_MUX = 7;
	localparam int PPC_CFG_PAL_EN = 6;
	localparam int PPC_CFG_RATE_HI = 5;
	localparam int PPC_CFG_RATE_LO = 4;
	localparam int PPC_CFG_OV1_BLINK = 3;
	localparam int PPC_CFG_OV0_BLINK = 2;
	localparam int PPC_CFG_OV1_DISP = 1;
	localparam int PPC_CFG_OV0_DISP = 0;
	localparam logic [6:0] PPC_BLINK_16 = 7'h10;
	localparam logic [6:0] PPC_BLINK_32 = 7'h20;
	localparam logic [6:0] PPC_BLINK_48 = 7'h30;
	localparam logic [6:0] PPC_BLINK_64 = 7'h40;
	localparam logic [8:0] PPC_RETRACE_LOADS = 9'h100;
	localparam logic [2:0] PPC_SLOT_LAST4 = 3'h3;
	localparam logic [2:0] PPC_SLOT_LAST5 = 3'h4;
	localparam logic PPC_BLINK_ON_RST = 1'b1;

	typedef struct packed {
		logic sync;
		logic blank_n;
		logic [1:0] overlay;
		logic [7:0] addr;
	} ppc_pixel_t;

	typedef struct packed {
		logic use_palette;
		logic sync;
		logic blank_n;
		logic [1:0] overlay;
		logic [7:0] addr;
	} ppc_pix_out_t;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} ppc_rgb_t;

	typedef struct packed {
		logic ce_n;
		logic rd;
		logic [2:0] sel;
		logic [7:0] data;
	} ppc_host_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] rmask;
		logic [7:0] bmask;
		logic [3:0] test;
		ppc_host_t host_s1;
		ppc_host_t host_s2;
		logic ce_prev;
		logic [7:0] rd_data;
		logic [1:0] ld_s;
		logic ld_prev;
		ppc_pixel_t [PPC_NPIX-1:0] pix_s1;
		ppc_pixel_t [PPC_NPIX-1:0] pix_s2;
		ppc_pixel_t [PPC_NPIX-1:0] lat;
		logic [2:0] slot;
		logic [8:0] blank_cnt;
		logic [6:0] vcount;
		logic blink_on;
		ppc_pix_out_t out;
	} ppc_state_t;
endpackage

// ==== ppc_palette_pixel_control_regs.sv ====
/*
 host registers of the palette device and the per-pixel gating they steer.
 assumes host strobe, data and pixel load strobe are asynchronous pins, held
 stable for several clocks; the palette RAM and overlay registers sit outside.
*/
`timescale 1ns/100ps
module ppc_palette_pixel_control_regs (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// host port
	input wire logic i_host_ce_n,
	input wire logic i_host_rd,
	input wire logic [2:0] i_host_sel,
	input wire logic [7:0] i_host_data,
	output logic [7:0] o_host_data,
	output logic o_host_data_oe,
	// frame buffer side
	input wire logic i_pixel_load_strobe,
	input wire ppc_pkg::ppc_pixel_t [ppc_pkg::PPC_NPIX-1:0] i_pixels,
	// palette side
	input wire ppc_pkg::ppc_rgb_t i_dac_color,
	output ppc_pkg::ppc_pix_out_t o_pixel
);
	ppc_pkg::ppc_state_t st_q;
	ppc_pkg::ppc_state_t st_d;
	logic load_evt;
	logic host_start;
	logic retrace_evt;
	logic mux5;

	function automatic logic [6:0] on_len(input logic [1:0] rate);
		unique case (rate)
			2'b00: on_len = ppc_pkg::PPC_BLINK_16;
			2'b01: on_len = ppc_pkg::PPC_BLINK_16;
			2'b10: on_len = ppc_pkg::PPC_BLINK_32;
			2'b11: on_len = ppc_pkg::PPC_BLINK_64;
		endcase
	endfunction

	function automatic logic [6:0] off_len(input logic [1:0] rate);
		unique case (rate)
			2'b00: off_len = ppc_pkg::PPC_BLINK_48;
			2'b01: off_len = ppc_pkg::PPC_BLINK_16;
			2'b10: off_len = ppc_pkg::PPC_BLINK_32;
			2'b11: off_len = ppc_pkg::PPC_BLINK_64;
		endcase
	endfunction

	// one-hot colour select; b3 high picks low nibble
	function automatic logic [3:0] dac_nibble(input logic [3:0] sel, input ppc_pkg::ppc_rgb_t c);
		logic [7:0] v;
		v = 8'h00;
		unique case (sel[2:0])
			3'b001: v = c.red;
			3'b010: v = c.green;
			3'b100: v = c.blue;
			default: v = 8'h00;
		endcase
		dac_nibble = sel[3] ? v[3:0] : v[7:4];
	endfunction

	assign mux5 = st_q.cfg[ppc_pkg::PPC_CFG_MUX];
	assign load_evt = st_q.ld_s[1] & ~st_q.ld_prev;
	assign host_start = st_q.ce_prev & ~st_q.host_s2.ce_n;
	assign retrace_evt = load_evt & ~st_q.pix_s2[0].blank_n
		& (st_q.blank_cnt == ppc_pkg::PPC_RETRACE_LOADS - 9'h001);

	always_comb begin
		ppc_pkg::ppc_pixel_t p;
		logic [1:0] rate;
		logic [6:0] vnext;
		logic [7:0] bgate;
		p = '0;
		rate = {st_q.cfg[ppc_pkg::PPC_CFG_RATE_HI], st_q.cfg[ppc_pkg::PPC_CFG_RATE_LO]};
		vnext = st_q.vcount + 7'h01;
		bgate = 8'h00;
		st_d = st_q;
		st_d.host_s1 = '{ce_n: i_host_ce_n, rd: i_host_rd, sel: i_host_sel, data: i_host_data};
		st_d.host_s2 = st_q.host_s1;
		st_d.ce_prev = st_q.host_s2.ce_n;
		st_d.ld_s = {st_q.ld_s[0], i_pixel_load_strobe};
		st_d.ld_prev = st_q.ld_s[1];
		st_d.pix_s1 = i_pixels;
		st_d.pix_s2 = st_q.pix_s1;

		// host writes take effect once per strobe
		if (host_start && !st_q.host_s2.rd) begin
			unique case (st_q.host_s2.sel)
				ppc_pkg::PPC_IDX_READ_MASK: st_d.rmask = st_q.host_s2.data;
				ppc_pkg::PPC_IDX_BLINK_MASK: st_d.bmask = st_q.host_s2.data;
				ppc_pkg::PPC_IDX_CONFIG: st_d.cfg = st_q.host_s2.data;
				ppc_pkg::PPC_IDX_TEST: st_d.test = st_q.host_s2.data[3:0];
				default: st_d.rd_data = st_q.rd_data;
			endcase
		end
		// read data refreshed every clock so a live DAC value is seen
		unique case (st_q.host_s2.sel)
			ppc_pkg::PPC_IDX_READ_MASK: st_d.rd_data = st_q.rmask;
			ppc_pkg::PPC_IDX_BLINK_MASK: st_d.rd_data = st_q.bmask;
			ppc_pkg::PPC_IDX_CONFIG: st_d.rd_data = st_q.cfg;
			ppc_pkg::PPC_IDX_TEST: st_d.rd_data = {dac_nibble(st_q.test, i_dac_color), st_q.test};
			default: st_d.rd_data = 8'h00;
		endcase

		// retrace detection and blink phase
		if (load_evt) begin
			if (st_q.pix_s2[0].blank_n) begin
				st_d.blank_cnt = 9'h000;
			end else if (st_q.blank_cnt != ppc_pkg::PPC_RETRACE_LOADS) begin
				st_d.blank_cnt = st_q.blank_cnt + 9'h001;
			end
		end
		if (retrace_evt) begin
			if ({1'b0, vnext} >= {1'b0, on_len(rate)} + {1'b0, off_len(rate)}) begin
				vnext = 7'h00;
			end
			st_d.vcount = vnext;
			st_d.blink_on = vnext < on_len(rate);
		end

		// capture with overlay gating, then serialise one pixel a clock
		if (load_evt) begin
			for (int i = 0; i < ppc_pkg::PPC_NPIX; i++) begin
				p = st_q.pix_s2[i];
				if (!st_q.cfg[ppc_pkg::PPC_CFG_OV0_DISP]) begin
					p.overlay[0] = 1'b0;
				end
				if (!st_q.cfg[ppc_pkg::PPC_CFG_OV1_DISP]) begin
					p.overlay[1] = 1'b0;
				end
				if (st_q.cfg[ppc_pkg::PPC_CFG_OV0_BLINK] && !st_q.blink_on) begin
					p.overlay[0] = 1'b0;
				end
				if (st_q.cfg[ppc_pkg::PPC_CFG_OV1_BLINK] && !st_q.blink_on) begin
					p.overlay[1] = 1'b0;
				end
				if (i == ppc_pkg::PPC_NPIX - 1 && !mux5) begin
					p = '0;
				end
				st_d.lat[i] = p;
			end
			st_d.slot = 3'h0;
		end else if (st_q.slot < (mux5 ? ppc_pkg::PPC_SLOT_LAST5 : ppc_pkg::PPC_SLOT_LAST4)) begin
			st_d.slot = st_q.slot + 3'h1;
		end else begin
			// clamp after a five to four switch so the slot never leaves the latch
			st_d.slot = mux5 ? ppc_pkg::PPC_SLOT_LAST5 : ppc_pkg::PPC_SLOT_LAST4;
		end

		p = st_q.lat[st_q.slot];
		bgate = st_q.blink_on ? 8'hFF : ~st_q.bmask;
		st_d.out.addr = p.addr & st_q.rmask & bgate;
		st_d.out.overlay = p.overlay;
		st_d.out.use_palette = st_q.cfg[ppc_pkg::PPC_CFG_PAL_EN] && p.overlay == 2'b00;
		st_d.out.sync = p.sync;
		st_d.out.blank_n = p.blank_n;
	end

	// host registers deliberately left out of the reset branch
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q.host_s1 <= '1;
			st_q.host_s2 <= '1;
			st_q.ce_prev <= 1'b1;
			st_q.rd_data <= 8'h00;
			st_q.ld_s <= 2'b00;
			st_q.ld_prev <= 1'b0;
			st_q.pix_s1 <= '0;
			st_q.pix_s2 <= '0;
			st_q.lat <= '0;
			st_q.slot <= 3'h0;
			st_q.blank_cnt <= 9'h000;
			st_q.vcount <= 7'h00;
			st_q.blink_on <= ppc_pkg::PPC_BLINK_ON_RST;
			st_q.out <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_host_data = st_q.rd_data;
	assign o_host_data_oe = ~st_q.host_s2.ce_n & st_q.host_s2.rd;
	assign o_pixel = st_q.out;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_ov0_disp_off: assert property (load_evt && !st_q.cfg[0] |=> !st_q.lat[0].overlay[0])
		else $error("overlay 0 passed while display disabled");
	a_ov1_disp_off: assert property (load_evt && !st_q.cfg[1] |=> !st_q.lat[2].overlay[1])
		else $error("overlay 1 passed while display disabled");
	a_ov1_blink_off: assert property (load_evt && st_q.cfg[3] && !st_q.blink_on |=> !st_q.lat[1].overlay[1])
		else $error("overlay 1 not blanked in off phase");
	a_ov0_blink_pass: assert property (load_evt && st_q.cfg[0] && !st_q.cfg[2]
		|=> st_q.lat[3].overlay[0] == $past(st_q.pix_s2[3].overlay[0]))
		else $error("overlay 0 altered with blink disabled");
	a_fifth_ignored: assert property (load_evt && !mux5 |=> st_q.lat[4] == '0)
		else $error("fifth pixel kept in four pixel mode");
	a_slot_range: assert property (!mux5 && !load_evt |=> st_q.slot <= 3'h3)
		else $error("slot beyond fourth pixel in four pixel mode");
	a_read_mask: assert property ((o_pixel.addr & ~$past(st_q.rmask)) == 8'h00)
		else $error("masked plane reached palette address");
	a_blink_mask: assert property (!$past(st_q.blink_on) |-> (o_pixel.addr & $past(st_q.bmask)) == 8'h00)
		else $error("blink plane passed in off phase");
	a_palette_pick: assert property (o_pixel.use_palette |-> $past(st_q.cfg[6]) && o_pixel.overlay == 2'b00)
		else $error("palette chosen against select rules");
	a_blink_retrace: assert property ($changed(st_q.blink_on) |-> $past(retrace_evt))
		else $error("blink phase changed outside retrace");
	a_test_write: assert property (host_start && !st_q.host_s2.rd && st_q.host_s2.sel == 3'h7
		|=> st_q.test == $past(st_q.host_s2.data[3:0]))
		else $error("test select not written");
	a_cfg_write: assert property (host_start && !st_q.host_s2.rd && st_q.host_s2.sel == 3'h6
		|=> ##1 o_host_data == st_q.cfg || $past(st_q.host_s2.sel) != 3'h6)
		else $error("config readback differs from register");
endmodule

// ==== ppc_pixel_source.sv ====
/*
 frame buffer model: divides the pixel clock into the load strobe and holds pixel sets.
 assumes the bench tells it the mux ratio in use and supplies each pixel set.
*/
`timescale 1ns/100ps
module ppc_pixel_source (
	// clock
	input wire logic i_clock,
	// control from bench
	input wire logic i_five,
	input wire ppc_pkg::ppc_pixel_t [ppc_pkg::PPC_NPIX-1:0] i_pixels,
	// design side
	output logic o_load,
	output ppc_pkg::ppc_pixel_t [ppc_pkg::PPC_NPIX-1:0] o_pixels
);
	logic [2:0] cnt_q = 3'h0;
	initial o_load = 1'b0;
	initial o_pixels = '0;
	always @(posedge i_clock) begin
		cnt_q <= (cnt_q >= (i_five ? 3'h4 : 3'h3)) ? 3'h0 : cnt_q + 3'h1;
		o_load <= (cnt_q < 3'h2);
		// new set mid period, well away from the strobe rise
		if (cnt_q == 3'h2) begin
			o_pixels <= i_five ? i_pixels : {12'h000, i_pixels[3:0]};
		end
	end
endmodule

// ==== tb_ppc_palette_pixel_control_regs.sv ====
/*
 self-checking bench for the palette pixel control registers.
 assumes the pixel source model and the design; host strobe held long for the synchroniser.
*/
`timescale 1ns/100ps
module tb_ppc_palette_pixel_control_regs;
	logic clock;
	logic rst_n;
	logic ce_n;
	logic rd;
	logic [2:0] sel;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic oe;
	logic load;
	logic five;
	ppc_pkg::ppc_pixel_t [ppc_pkg::PPC_NPIX-1:0] src;
	ppc_pkg::ppc_pixel_t [ppc_pkg::PPC_NPIX-1:0] pins;
	ppc_pkg::ppc_rgb_t dac;
	ppc_pkg::ppc_pix_out_t pix;
	ppc_pkg::ppc_pix_out_t seen [20];
	int errors = 0;
	int comparisons = 0;
	int seed = 74;
	logic [7:0] cfg, rm, bm, got, ch;
	logic [7:0] vals [3];
	logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h4, 4'h9, 4'hA, 4'hC};
	logic blink_on;

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	ppc_pixel_source i_ppc_pixel_source (.i_clock(clock), .i_five(five), .i_pixels(src), .o_load(load),
		.o_pixels(pins));
	ppc_palette_pixel_control_regs i_ppc_palette_pixel_control_regs (.i_clock(clock), .i_rst_n(rst_n),
		.i_host_ce_n(ce_n), .i_host_rd(rd), .i_host_sel(sel), .i_host_data(wdata), .o_host_data(rdata),
		.o_host_data_oe(oe), .i_pixel_load_strobe(load), .i_pixels(pins), .i_dac_color(dac), .o_pixel(pix));

	task automatic check(input logic [12:0] seen_v, input logic [12:0] exp_v);
		comparisons++;
		if (seen_v !== exp_v) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic test_done;
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// strobe held well past the two-flop synchroniser before release
	task automatic host(input logic r, input logic [2:0] s, input logic [7:0] d);
		@(negedge clock);
		ce_n = 1'b0;
		rd = r;
		sel = s;
		wdata = d;
		repeat (5) @(negedge clock);
		got = rdata;
		if (r) check(13'(oe), 13'h1);
		else check(13'(oe), 13'h0);
		@(negedge clock);
		ce_n = 1'b1;
		repeat (4) @(negedge clock);
	endtask

	function automatic ppc_pkg::ppc_pix_out_t exp_pix(input ppc_pkg::ppc_pixel_t p);
		ppc_pkg::ppc_pix_out_t e;
		logic [1:0] ov;
		ov = p.overlay & cfg[1:0] & ~(cfg[3:2] & {2{~blink_on}});
		e.use_palette = cfg[6] & (ov == 2'h0);
		e.sync = p.sync;
		e.blank_n = p.blank_n;
		e.overlay = ov;
		e.addr = p.addr & rm & ~(bm & {8{~blink_on}});
		return e;
	endfunction

	// output phase to the load is free, so align on the first pixel
	task automatic pixels_check;
		int k;
		int n;
		k = 0;
		n = cfg[7] ? 5 : 4;
		repeat (12) @(negedge clock);
		for (int i = 0; i < 20; i++) begin
			@(negedge clock);
			seen[i] = pix;
		end
		for (int i = 9; i >= 0; i--) if (seen[i] === exp_pix(pins[0])) k = i;
		for (int j = 0; j < 10; j++) check(seen[k+j], exp_pix(pins[j % n]));
	endtask

	task automatic setup(input logic [7:0] c, input logic [7:0] r, input logic [7:0] b);
		cfg = c;
		rm = r;
		bm = b;
		five = c[7];
		for (int p = 0; p < 5; p++) src[p] = 12'(($random(seed) & 12'hBF8) | 12'h400 | p);
		vals = '{rm, bm, cfg};
		for (int i = 0; i < 3; i++) begin
			host(1'b0, ppc_pkg::PPC_IDX_READ_MASK + 3'(i), vals[i]);
			host(1'b1, ppc_pkg::PPC_IDX_READ_MASK + 3'(i), 8'h00);
			check(13'(got), 13'(vals[i]));
		end
	endtask

	initial begin
		repeat (30000) @(posedge clock);
		errors++;
		test_done;
	end

	initial begin
		ce_n = 1'b1;
		rd = 1'b0;
		sel = 3'h0;
		wdata = 8'h00;
		rst_n = 1'b0;
		five = 1'b0;
		src = '0;
		dac = '0;
		blink_on = 1'b1;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		for (int t = 0; t < 8; t++) begin
			ch = 8'($random(seed));
			ch[1:0] = ch[1:0] | ch[3:2];
			setup(ch, 8'($random(seed)) | 8'h07, 8'($random(seed)) & 8'hF8);
			pixels_check;
		end
		setup(8'h40, 8'h07, 8'hF8);
		pixels_check;
		host(1'b1, 3'h2, 8'hFF);
		check(13'(got), 13'h0);
		dac = 24'($random(seed));
		for (int i = 0; i < 6; i++) begin
			host(1'b0, ppc_pkg::PPC_IDX_TEST, {4'hF, codes[i]});
			host(1'b1, ppc_pkg::PPC_IDX_TEST, 8'h00);
			ch = codes[i][0] ? dac.red : (codes[i][1] ? dac.green : dac.blue);
			check(13'(got), 13'({codes[i][3] ? ch[3:0] : ch[7:4], codes[i]}));
		end
		setup(8'h5F, 8'hFF, 8'hF8);
		for (int v = 0; v < 16; v++) begin
			for (int p = 0; p < 5; p++) src[p].blank_n = 1'b0;
			repeat (1040) @(negedge clock);
			for (int p = 0; p < 5; p++) src[p].blank_n = 1'b1;
			repeat (40) @(negedge clock);
			if (v == 14) pixels_check;
		end
		blink_on = 1'b0;
		pixels_check;
		test_done;
	end
endmodule
